// >>> common/smsr_defs.svh
`ifndef SMSR_DEFS_SVH
`define SMSR_DEFS_SVH

// Register byte offsets
`define SMSR_OFF_CTRL 8'h00
`define SMSR_OFF_BAUD 8'h04
`define SMSR_OFF_DATA 8'h08
`define SMSR_OFF_IRQST 8'h0C
`define SMSR_OFF_IRQEN 8'h10
`define SMSR_OFF_MODE 8'h14

// rx_status_ctrl bit positions
`define SMSR_B_NINTH 0
`define SMSR_B_OVERRUN 1
`define SMSR_B_FRAMING 2
`define SMSR_B_CONT 4
`define SMSR_B_SINGLE 5
`define SMSR_B_NINEBIT 6
`define SMSR_B_PORTEN 7

// Mode register bit positions
`define SMSR_B_SYNC 0
`define SMSR_B_CLKMST 1

// Interrupt status and enable bit positions
`define SMSR_B_RXDONE 0
`define SMSR_B_OVREVT 1

// Counts and reset values
`define SMSR_FIFO_FULL 2'd2
`define SMSR_LAST_BIT8 4'd7
`define SMSR_LAST_BIT9 4'd8
`define SMSR_BAUD_RST 8'h00

`endif

// >>> common/smsr_pkg.sv
package smsr_pkg;

  typedef enum logic [1:0] {
    SMSR_IDLE = 2'b01,
    SMSR_SHIFT = 2'b10
  } smsr_fsm_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } smsr_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } smsr_apb_rsp_type;

  typedef struct packed {
    logic ninth;
    logic framing;
    logic [7:0] data;
  } smsr_word_type;

  typedef struct packed {
    smsr_fsm_type st;
    logic portEn;
    logic nineBitEn;
    logic singleEn;
    logic contEn;
    logic syncMode;
    logic clkMaster;
    logic overrun;
    logic [7:0] baudGen;
    logic [7:0] baudCnt;
    logic [3:0] bitCnt;
    logic [8:0] shifter;
    logic shiftClk;
    logic shiftClkOe;
    smsr_word_type [1:0] fifo;
    logic rdPtr;
    logic [1:0] count;
    logic rxComplete;
    logic ovrEvent;
    logic irqEnRx;
    logic irqEnOvr;
    logic irq;
    logic [2:0] dinSync;
    logic dinStable;
    smsr_apb_rsp_type rsp;
  } smsr_regs_type;

endpackage

// >>> logic/smsr_receiver.sv
`timescale 1ns/10ps
`include "smsr_defs.svh"

module smsr_receiver
  import smsr_pkg::*;
(
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic rst, // Asynchronous reset, active high
  input smsr_apb_req_type apbReq, // APB request from master
  output smsr_apb_rsp_type apbRsp, // APB answer
  input wire logic serialDataIn, // Data line from slave
  output logic shiftClkOut, // Shift clock level
  output logic shiftClkOe, // Shift clock drive enable
  output logic irq // Level interrupt, active high
);

  smsr_regs_type r;
  smsr_regs_type n;

  function automatic logic [3:0] lastBit(input logic nine);
    lastBit = nine ? `SMSR_LAST_BIT9 : `SMSR_LAST_BIT8;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `SMSR_OFF_CTRL) || (a == `SMSR_OFF_BAUD) ||
             (a == `SMSR_OFF_DATA) || (a == `SMSR_OFF_IRQST) ||
             (a == `SMSR_OFF_IRQEN) || (a == `SMSR_OFF_MODE);
  endfunction

  function automatic logic [31:0] readReg(input smsr_regs_type s,
                                          input logic [7:0] a);
    smsr_word_type head;
    logic any;
    head = s.fifo[s.rdPtr];
    any = (s.count != 2'd0);
    readReg = 32'h0000_0000;
    unique case (a)
      `SMSR_OFF_CTRL:
      begin
        readReg[`SMSR_B_PORTEN] = s.portEn;
        readReg[`SMSR_B_NINEBIT] = s.nineBitEn;
        readReg[`SMSR_B_SINGLE] = s.singleEn;
        readReg[`SMSR_B_CONT] = s.contEn;
        readReg[`SMSR_B_FRAMING] = any & head.framing;
        readReg[`SMSR_B_OVERRUN] = s.overrun;
        readReg[`SMSR_B_NINTH] = any & head.ninth;
      end
      `SMSR_OFF_BAUD:
      begin
        readReg[7:0] = s.baudGen;
      end
      `SMSR_OFF_DATA:
      begin
        readReg[7:0] = any ? head.data : 8'h00;
      end
      `SMSR_OFF_IRQST:
      begin
        readReg[`SMSR_B_RXDONE] = s.rxComplete;
        readReg[`SMSR_B_OVREVT] = s.ovrEvent;
      end
      `SMSR_OFF_IRQEN:
      begin
        readReg[`SMSR_B_RXDONE] = s.irqEnRx;
        readReg[`SMSR_B_OVREVT] = s.irqEnOvr;
      end
      `SMSR_OFF_MODE:
      begin
        readReg[`SMSR_B_SYNC] = s.syncMode;
        readReg[`SMSR_B_CLKMST] = s.clkMaster;
      end
      default:
      begin
        readReg = 32'h0000_0000;
      end
    endcase
  endfunction

  logic access;
  logic done;
  logic wr;
  logic rd;
  logic pop;
  logic push;
  logic wordEnd;
  logic enable;
  logic wrIdx;
  smsr_word_type word;

  always_comb
  begin
    n = r;
    push = 1'b0;
    wordEnd = 1'b0;
    word = '0;

    // Data pin synchroniser; dinStable follows only when the last two stages agree
    n.dinSync = {r.dinSync[1:0], serialDataIn};
    if (r.dinSync[1] == r.dinSync[2])
    begin
      n.dinStable = r.dinSync[2];
    end

    // APB: one wait state so read data is settled before pready
    access = apbReq.psel & apbReq.penable;
    done = access & r.rsp.pready;
    n.rsp.pready = 1'b0;
    n.rsp.pslverr = 1'b0;
    if (access & ~r.rsp.pready)
    begin
      n.rsp.pready = 1'b1;
      n.rsp.prdata = readReg(r, apbReq.paddr);
      n.rsp.pslverr = ~mapped(apbReq.paddr);
    end
    wr = done & apbReq.pwrite & ~r.rsp.pslverr;
    rd = done & ~apbReq.pwrite & ~r.rsp.pslverr;
    pop = rd & (apbReq.paddr == `SMSR_OFF_DATA) & (r.count != 2'd0);

    // Continuous wins over single by simply being an enable too
    enable = r.portEn & r.syncMode & r.clkMaster &
             (r.singleEn | r.contEn);

    unique case (r.st)
      SMSR_IDLE:
      begin
        n.shiftClk = 1'b0;
        n.shiftClkOe = 1'b0;
        n.bitCnt = 4'd0;
        if (enable)
        begin
          n.st = SMSR_SHIFT;
          n.shiftClkOe = 1'b1;
          n.baudCnt = r.baudGen;
        end
      end
      SMSR_SHIFT:
      begin
        if (~enable)
        begin
          // Abort mid-word: partial word is dropped
          n.st = SMSR_IDLE;
          n.shiftClk = 1'b0;
          n.shiftClkOe = 1'b0;
          n.bitCnt = 4'd0;
          n.shifter = 9'h000;
        end
        else if (r.baudCnt == 8'h00)
        begin
          n.baudCnt = r.baudGen;
          n.shiftClk = ~r.shiftClk;
          if (r.shiftClk)
          begin
            // Falling edge of the shift clock
            n.shifter = {r.dinStable, r.shifter[8:1]};
            n.bitCnt = r.bitCnt + 4'd1;
            if (r.bitCnt == lastBit(r.nineBitEn))
            begin
              wordEnd = 1'b1;
              n.bitCnt = 4'd0;
              if (~r.contEn)
              begin
                n.singleEn = 1'b0;
                n.st = SMSR_IDLE;
                n.shiftClkOe = 1'b0;
              end
            end
          end
        end
        else
        begin
          n.baudCnt = r.baudCnt - 8'h01;
        end
      end
    endcase

    // Synchronous mode has no stop bit, so framing never flags
    if (r.nineBitEn)
    begin
      word.ninth = n.shifter[8];
      word.data = n.shifter[7:0];
    end
    else
    begin
      word.data = n.shifter[8:1];
    end
    word.framing = 1'b0;

    // Software writes land after the shifter so a same-cycle write wins
    if (wr)
    begin
      unique case (apbReq.paddr)
        `SMSR_OFF_CTRL:
        begin
          n.portEn = apbReq.pwdata[`SMSR_B_PORTEN];
          n.nineBitEn = apbReq.pwdata[`SMSR_B_NINEBIT];
          n.singleEn = apbReq.pwdata[`SMSR_B_SINGLE];
          n.contEn = apbReq.pwdata[`SMSR_B_CONT];
          if (r.contEn & ~apbReq.pwdata[`SMSR_B_CONT])
          begin
            n.overrun = 1'b0;
          end
        end
        `SMSR_OFF_BAUD:
        begin
          n.baudGen = apbReq.pwdata[7:0];
        end
        `SMSR_OFF_IRQST:
        begin
          if (apbReq.pwdata[`SMSR_B_OVREVT])
          begin
            n.ovrEvent = 1'b0;
          end
        end
        `SMSR_OFF_IRQEN:
        begin
          n.irqEnRx = apbReq.pwdata[`SMSR_B_RXDONE];
          n.irqEnOvr = apbReq.pwdata[`SMSR_B_OVREVT];
        end
        `SMSR_OFF_MODE:
        begin
          n.syncMode = apbReq.pwdata[`SMSR_B_SYNC];
          n.clkMaster = apbReq.pwdata[`SMSR_B_CLKMST];
        end
        default:
        begin
          n.baudGen = r.baudGen;
        end
      endcase
    end

    // Word arrival: full FIFO with no pop this cycle means overrun
    if (wordEnd & ~r.overrun)
    begin
      if ((r.count == `SMSR_FIFO_FULL) & ~pop)
      begin
        n.overrun = 1'b1;
        n.ovrEvent = 1'b1;
      end
      else
      begin
        push = 1'b1;
      end
    end

    // Freed slot and tail coincide when full, so one index serves
    wrIdx = r.rdPtr ^ r.count[0];
    if (push)
    begin
      n.fifo[wrIdx] = word;
    end
    if (pop)
    begin
      n.rdPtr = ~r.rdPtr;
    end
    n.count = r.count + {1'b0, push} - {1'b0, pop};

    // Hardware owns this flag; a new word beats the emptying read
    if (push)
    begin
      n.rxComplete = 1'b1;
    end
    else if (pop & (r.count == 2'd1))
    begin
      n.rxComplete = 1'b0;
    end

    n.irq = (n.rxComplete & n.irqEnRx) | (n.ovrEvent & n.irqEnOvr);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= SMSR_IDLE;
      r.baudGen <= `SMSR_BAUD_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign apbRsp = r.rsp;
  assign shiftClkOut = r.shiftClk;
  assign shiftClkOe = r.shiftClkOe;
  assign irq = r.irq;

endmodule // smsr_receiver

// >>> tb/smsr_receiver_props.sv
`timescale 1ns/10ps
`include "smsr_defs.svh"
module smsr_receiver_props
  import smsr_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input smsr_apb_req_type apbReq, // Request
  input smsr_apb_rsp_type apbRsp, // Answer
  input wire logic shiftClkOut, // Shift clock
  input wire logic shiftClkOe, // Clock drive
  input wire logic irq // Interrupt
);
  logic [7:0] baudQ, ctrlQ;
  logic [1:0] ienQ;
  logic [8:0] cntQ;
  logic prevQ, seenQ, tog, rxOn;
  assign tog = shiftClkOut ^ prevQ;
  assign rxOn = ctrlQ[7] & (ctrlQ[5] | ctrlQ[4]);
  // Shadows of software writes, so checks follow any setup
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      {baudQ, ctrlQ, ienQ, cntQ, prevQ, seenQ} <= '0;
    end
    else
    begin
      prevQ <= shiftClkOut;
      cntQ <= tog ? 9'h001 : cntQ + 9'h001;
      seenQ <= shiftClkOe & (seenQ | tog);
      if (apbReq.psel & apbReq.penable & apbRsp.pready & apbReq.pwrite)
      begin
        case (apbReq.paddr)
          `SMSR_OFF_BAUD: baudQ <= apbReq.pwdata[7:0];
          `SMSR_OFF_CTRL: ctrlQ <= apbReq.pwdata[7:0];
          `SMSR_OFF_IRQEN: ienQ <= apbReq.pwdata[1:0];
          default: ;
        endcase
      end
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  AST_CLK_IDLE: assert property (
    !shiftClkOe |-> !shiftClkOut) else $error("clock high undriven");
  AST_CLK_START: assert property (
    $rose(shiftClkOe) |-> !shiftClkOut) else $error("clock starts high");
  AST_CLK_HALF: assert property (
    tog && seenQ && shiftClkOe |-> cntQ == {1'b0, baudQ} + 9'h001)
    else $error("bad half period");
  AST_OE_EN: assert property (
    shiftClkOe |-> $past(rxOn)) else $error("clock driven while off");
  AST_IRQ_MASK: assert property (
    irq |-> ienQ != 2'h0) else $error("irq while masked");
  AST_RDY_WAIT: assert property (
    apbReq.psel && apbReq.penable && !$past(apbReq.penable) |->
    !apbRsp.pready ##1 apbRsp.pready) else $error("bad wait state");
  AST_RDY_PULSE: assert property (
    apbRsp.pready |=> !apbRsp.pready) else $error("pready too long");
  AST_BAD_ADDR: assert property (
    apbRsp.pready && apbReq.paddr > 8'h14 |-> apbRsp.pslverr)
    else $error("no error on unmapped");
endmodule // smsr_receiver_props

bind smsr_receiver smsr_receiver_props smsr_receiver_props_inst (.clk_sys,
  .rst, .apbReq, .apbRsp, .shiftClkOut, .shiftClkOe, .irq);

// >>> tb/smsr_slave_model.sv
`timescale 1ns/10ps
module smsr_slave_model
(
  input wire logic clk_sys, // Edge detect clock
  input wire logic shiftClk, // From master
  input wire logic shiftClkOe, // Master drives
  input wire logic nineBit, // Nine-bit words
  input wire logic [8:0] firstWord, // Then plus one per word
  output logic dataOut // To master
);
  logic prevQ = 1'b0;
  logic armedQ = 1'b0;
  logic [3:0] bitQ = 4'h0;
  logic [8:0] nQ = 9'h000;
  logic [8:0] cur;
  logic [8:0] nxt;
  assign cur = firstWord + nQ;
  assign nxt = cur + 9'h001;
  initial dataOut = 1'b0;
  // Bits change just after a falling edge, so each one stands a full
  // period and outlasts the master's three-stage synchroniser
  always @(posedge clk_sys)
  begin
    prevQ <= shiftClk;
    if (!shiftClkOe)
    begin
      // Released line flips, so no stale bit can pass
      dataOut <= ~dataOut;
      armedQ <= 1'b0;
      bitQ <= 4'h0;
      nQ <= 9'h000;
    end
    else if (!armedQ)
    begin
      dataOut <= cur[0];
      armedQ <= 1'b1;
      bitQ <= 4'h1;
    end
    else if (!shiftClk && prevQ)
    begin
      if (bitQ == {3'h0, nineBit} + 4'h8)
      begin
        dataOut <= nxt[0];
        bitQ <= 4'h1;
        nQ <= nQ + 9'h001;
      end
      else
      begin
        dataOut <= cur[bitQ];
        bitQ <= bitQ + 4'h1;
      end
    end
  end
endmodule // smsr_slave_model

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb
  import smsr_pkg::*;
;
  logic clk_sys, rst, sdata, shiftClkOut, shiftClkOe, irq, nineBit, lastErr;
  logic [8:0] firstWord;
  logic [31:0] rdData;
  smsr_apb_req_type req;
  smsr_apb_rsp_type apbRsp;
  int nErrors = 0;
  int comparisons = 0;
  smsr_receiver smsr_receiver_inst (.clk_sys, .rst, .apbReq(req), .apbRsp,
    .serialDataIn(sdata), .shiftClkOut, .shiftClkOe, .irq);
  smsr_slave_model smsr_slave_model_inst (.clk_sys, .shiftClk(shiftClkOut),
    .shiftClkOe, .nineBit, .firstWord, .dataOut(sdata));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("errors %0d comparisons %0d", nErrors, comparisons);
    if (nErrors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      nErrors++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // No cycle limit here; a hung slave is left to the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (apbRsp.pready !== 1'b1);
    rdData = apbRsp.prdata;
    lastErr = apbRsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdData & m, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic waitOe(input logic lvl);
    int n;
    n = 0;
    while (shiftClkOe !== lvl && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chkBit(shiftClkOe, lvl);
  endtask
  initial
  begin
    #3000000;
    nErrors++;
    test_done();
  end
  initial
  begin
    rst = 1'b1;
    req = '0;
    nineBit = 1'b0;
    firstWord = 9'h0A5;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h04, 32'hFF, 32'h0);
    wr(8'h04, 32'h3);
    wr(8'h14, 32'h3);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h90);
    repeat (30) @(posedge clk_sys);
    wr(8'h00, 32'h80);
    repeat (3) @(posedge clk_sys);
    chkBit(shiftClkOe, 1'b0);
    rd(8'h0C, 32'h1, 32'h0);
    wr(8'h00, 32'hA0);
    waitOe(1'b1);
    waitOe(1'b0);
    repeat (4) @(posedge clk_sys);
    chkBit(irq, 1'b1);
    rd(8'h00, 32'h32, 32'h0);
    wr(8'h10, 32'h0);
    repeat (2) @(posedge clk_sys);
    chkBit(irq, 1'b0);
    rd(8'h0C, 32'h1, 32'h1);
    rd(8'h08, 32'hFF, 32'hA5);
    rd(8'h0C, 32'h1, 32'h0);
    nineBit <= 1'b1;
    firstWord <= 9'h0FF;
    wr(8'h00, 32'hF0);
    repeat (400) @(posedge clk_sys);
    chkBit(shiftClkOe, 1'b1);
    rd(8'h00, 32'h13, 32'h12);
    rd(8'h08, 32'hFF, 32'hFF);
    rd(8'h00, 32'h1, 32'h1);
    rd(8'h08, 32'hFF, 32'h0);
    rd(8'h0C, 32'h3, 32'h2);
    wr(8'h0C, 32'h2);
    rd(8'h0C, 32'h2, 32'h0);
    wr(8'h00, 32'h80);
    rd(8'h00, 32'hFF, 32'h80);
    rd(8'h20, 32'hFFFF_FFFF, 32'h0);
    chkBit(lastErr, 1'b1);
    test_done();
  end
endmodule // tb
